// [hdl/bal_core.sv]
// byte alu subset with accumulator, flags, 128-byte file and wishbone slave
// assumes a classic wishbone master on clk_i; one instruction at a time
//
// Function
// - subtract gives file minus accumulator; address 0..127; dest 0 acc, 1 file
// - subtract carry set when accumulator not above file, else cleared
// - subtract half carry set when acc low nibble not above file nibble
// - literal xor with accumulator, result to accumulator, only zero flag
// - nibble exchange of file register to chosen destination, flags untouched
// - xor accumulator with file register to chosen destination, only zero flag
// - every operation runs over one instruction cycle of four oscillator periods
`timescale 1ns/1ps
`include "bal_defs.svh"

module bal_core (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o
);
    bal_pkg::bal_phase_t phase;
    logic                cycle_end;
    logic [7:0]          file_mem [`BAL_FILE_DEPTH];
    bal_pkg::bal_op_t    cmd_op;
    logic                cmd_dst;
    logic [6:0]          cmd_adr;
    logic [7:0]          cmd_lit;
    logic                pending;
    logic                run;
    logic [7:0]          acc;
    logic                flag_c;
    logic                half_carry_flag;
    logic                flag_z;
    logic [6:0]          fidx;
    logic [7:0]          opnd;
    logic [7:0]          res;
    logic                res_c;
    logic                res_dc;
    logic                wb_req;
    logic                wb_wr;
    logic                busy;
    logic                wb_fire;
    logic [31:0]         next_rdata;
    logic [8:0]          diff;
    logic [8:0]          diff_lo;

    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction

    function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
        return {1'b0, a} + {1'b0, ~b} + 9'h001;
    endfunction

    bal_phase_gen u_phase (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .phase_o     (phase),
        .cycle_end_o (cycle_end)
    );

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_req && wb_we_i;
    assign busy    = pending || run;
    assign busy_o  = busy;
    assign wb_fire = run && cycle_end;
    // carry out of the nibble-only difference is the no-borrow of the low nibble
    assign diff    = sub9(opnd, acc);
    assign diff_lo = sub9({4'h0, opnd[3:0]}, {4'h0, acc[3:0]});

    // bus ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            `BAL_OFF_CMD: begin
                next_rdata[`BAL_CMD_OP_LSB +: 2]  = cmd_op;
                next_rdata[`BAL_CMD_DST_BIT]      = cmd_dst;
                next_rdata[`BAL_CMD_ADR_LSB +: 7] = cmd_adr;
                next_rdata[`BAL_CMD_LIT_LSB +: 8] = cmd_lit;
                next_rdata[`BAL_CMD_BUSY_BIT]     = busy;
            end
            `BAL_OFF_ACC:    next_rdata[7:0] = acc;
            `BAL_OFF_STATUS: begin
                next_rdata[`BAL_ST_C_BIT]  = flag_c;
                next_rdata[`BAL_ST_DC_BIT] = half_carry_flag;
                next_rdata[`BAL_ST_Z_BIT]  = flag_z;
            end
            `BAL_OFF_FIDX:   next_rdata[6:0] = fidx;
            `BAL_OFF_FDATA:  next_rdata[7:0] = file_mem[fidx];
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // command latch; a new command while busy is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_op  <= bal_pkg::BAL_SUB;
            cmd_dst <= 1'b0;
            cmd_adr <= 7'h00;
            cmd_lit <= 8'h00;
        end else if (wb_wr && wb_adr_i == `BAL_OFF_CMD && wb_sel_i[0] && !busy) begin
            cmd_op  <= bal_pkg::bal_op_t'(wb_dat_i[`BAL_CMD_OP_LSB +: 2]);
            cmd_dst <= wb_dat_i[`BAL_CMD_DST_BIT];
            if (wb_sel_i[1]) begin
                cmd_adr <= wb_dat_i[`BAL_CMD_ADR_LSB +: 7];
            end
            if (wb_sel_i[2]) begin
                cmd_lit <= wb_dat_i[`BAL_CMD_LIT_LSB +: 8];
            end
        end
    end

    // start waits for the next Q1 so each op fills one whole cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending <= 1'b0;
            run     <= 1'b0;
        end else begin
            if (wb_wr && wb_adr_i == `BAL_OFF_CMD && wb_sel_i[0] && !busy) begin
                pending <= 1'b1;
            end else if (pending && phase == bal_pkg::BAL_Q4) begin
                pending <= 1'b0;
            end
            if (pending && phase == bal_pkg::BAL_Q4) begin
                run <= 1'b1;
            end else if (wb_fire) begin
                run <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fidx <= 7'h00;
        end else if (wb_wr && wb_adr_i == `BAL_OFF_FIDX && wb_sel_i[0]) begin
            fidx <= wb_dat_i[6:0];
        end
    end

    // Q2 fetch and Q3 compute
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opnd   <= 8'h00;
            res    <= 8'h00;
            res_c  <= 1'b0;
            res_dc <= 1'b0;
        end else if (run && phase == bal_pkg::BAL_Q2) begin
            opnd <= file_mem[cmd_adr];
        end else if (run && phase == bal_pkg::BAL_Q3) begin
            unique case (cmd_op)
                bal_pkg::BAL_SUB: begin
                    res    <= diff[7:0];
                    res_c  <= diff[8];
                    res_dc <= diff_lo[8];
                end
                bal_pkg::BAL_XORL: res <= acc ^ cmd_lit;
                bal_pkg::BAL_SWAP: res <= {opnd[3:0], opnd[7:4]};
                bal_pkg::BAL_XORF: res <= acc ^ opnd;
            endcase
        end
    end

    // Q4 writeback; bus writes to acc, flags, file are refused while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= `BAL_ACC_RST;
        end else if (wb_fire) begin
            if (cmd_op == bal_pkg::BAL_XORL || !cmd_dst) begin
                acc <= res;
            end
        end else if (wb_wr && wb_adr_i == `BAL_OFF_ACC && wb_sel_i[0] && !busy) begin
            acc <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (wb_fire && cmd_op != bal_pkg::BAL_XORL && cmd_dst) begin
            file_mem[cmd_adr] <= res;
        end else if (wb_wr && wb_adr_i == `BAL_OFF_FDATA && wb_sel_i[0] && !busy) begin
            file_mem[fidx] <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_c          <= `BAL_FLAG_RST;
            half_carry_flag <= `BAL_FLAG_RST;
            flag_z          <= `BAL_FLAG_RST;
        end else if (wb_fire) begin
            if (cmd_op == bal_pkg::BAL_SUB) begin
                flag_c          <= res_c;
                half_carry_flag <= res_dc;
            end
            if (cmd_op != bal_pkg::BAL_SWAP) begin
                flag_z <= is_zero(res);
            end
        end else if (wb_wr && wb_adr_i == `BAL_OFF_STATUS && wb_sel_i[0] && !busy) begin
            flag_c          <= wb_dat_i[`BAL_ST_C_BIT];
            half_carry_flag <= wb_dat_i[`BAL_ST_DC_BIT];
            flag_z          <= wb_dat_i[`BAL_ST_Z_BIT];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_sub_val;
        wb_fire && cmd_op == bal_pkg::BAL_SUB && !cmd_dst |=> acc == $past(opnd) - $past(acc);
    endproperty
    a_sub_val: assert property (p_sub_val) else $error("subtract result wrong");

    property p_sub_c;
        wb_fire && cmd_op == bal_pkg::BAL_SUB |=> flag_c == ($past(acc) <= $past(opnd));
    endproperty
    a_sub_c: assert property (p_sub_c) else $error("subtract carry wrong");

    property p_sub_dc;
        wb_fire && cmd_op == bal_pkg::BAL_SUB
            |=> half_carry_flag == ($past(acc[3:0]) <= $past(opnd[3:0]));
    endproperty
    a_sub_dc: assert property (p_sub_dc) else $error("subtract half carry wrong");

    property p_xorl;
        wb_fire && cmd_op == bal_pkg::BAL_XORL
            |=> acc == ($past(acc) ^ $past(cmd_lit)) && $stable(flag_c) && $stable(half_carry_flag);
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");

    property p_swap;
        wb_fire && cmd_op == bal_pkg::BAL_SWAP
            |=> $stable(flag_c) && $stable(half_carry_flag) && $stable(flag_z);
    endproperty
    a_swap: assert property (p_swap) else $error("swap touched a flag");

    property p_swap_acc;
        run && phase == bal_pkg::BAL_Q2 && cmd_op == bal_pkg::BAL_SWAP && !cmd_dst
            |=> ##2 acc[7:4] == $past(file_mem[cmd_adr][3:0], 3)
                && acc[3:0] == $past(file_mem[cmd_adr][7:4], 3);
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("swap value wrong");

    property p_xorf;
        wb_fire && cmd_op == bal_pkg::BAL_XORF && cmd_dst
            |=> $stable(acc) && $stable(flag_c) && flag_z == ($past(acc) == $past(opnd));
    endproperty
    a_xorf: assert property (p_xorf) else $error("register xor wrong");

    property p_cycle;
        $rose(run) |-> phase == bal_pkg::BAL_Q1 ##0 run [*4] ##1 !run;
    endproperty
    a_cycle: assert property (p_cycle) else $error("op not one four-phase cycle");

    property p_zero;
        wb_fire && cmd_op != bal_pkg::BAL_SWAP |=> flag_z == ($past(res) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    c_sub:  cover property (wb_fire && cmd_op == bal_pkg::BAL_SUB && res_c && !res_dc);
    c_xorl: cover property (wb_fire && cmd_op == bal_pkg::BAL_XORL && res == 8'h00);
    c_swap: cover property (wb_fire && cmd_op == bal_pkg::BAL_SWAP && cmd_dst);
    c_xorf: cover property (wb_fire && cmd_op == bal_pkg::BAL_XORF && !cmd_dst);
endmodule

// [hdl/bal_defs.svh]
// constants for the byte alu subset: bus offsets, fields, resets, timing
// assumes inclusion by bare name from package and modules
`ifndef BAL_DEFS_SVH
`define BAL_DEFS_SVH

`define BAL_ADR_W        8
`define BAL_OFF_CMD      8'h00
`define BAL_OFF_ACC      8'h04
`define BAL_OFF_STATUS   8'h08
`define BAL_OFF_FIDX     8'h0C
`define BAL_OFF_FDATA    8'h10

`define BAL_CMD_OP_LSB   0
`define BAL_CMD_DST_BIT  2
`define BAL_CMD_ADR_LSB  8
`define BAL_CMD_LIT_LSB  16
`define BAL_CMD_BUSY_BIT 31

`define BAL_ST_C_BIT     0
`define BAL_ST_DC_BIT    1
`define BAL_ST_Z_BIT     2

`define BAL_OP_SUB       2'h0
`define BAL_OP_XORL      2'h1
`define BAL_OP_SWAP      2'h2
`define BAL_OP_XORF      2'h3

`define BAL_FILE_DEPTH   128
`define BAL_ACC_RST      8'h00
`define BAL_FLAG_RST     1'b0

`define BAL_OSC_PER_NS   10
`define BAL_CLK_PER_NS   10
`define BAL_TCY_OSC      4
`define BAL_TCY_CLKS     ((`BAL_TCY_OSC * `BAL_OSC_PER_NS) / `BAL_CLK_PER_NS)

`endif

// [hdl/bal_pkg.sv]
// types for the byte alu subset
// assumes bal_defs.svh on the include path
`include "bal_defs.svh"

package bal_pkg;
    typedef enum logic [1:0] {
        BAL_SUB  = `BAL_OP_SUB,
        BAL_XORL = `BAL_OP_XORL,
        BAL_SWAP = `BAL_OP_SWAP,
        BAL_XORF = `BAL_OP_XORF
    } bal_op_t;

    typedef enum logic [1:0] {
        BAL_Q1,
        BAL_Q2,
        BAL_Q3,
        BAL_Q4
    } bal_phase_t;
endpackage

// [hdl/bal_phase_gen.sv]
// four-phase instruction cycle sequencer, one phase per oscillator period
// assumes oscillator period equals one clk_i period
`timescale 1ns/1ps
`include "bal_defs.svh"

module bal_phase_gen (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    output bal_pkg::bal_phase_t    phase_o,
    output logic                   cycle_end_o
);
    bal_pkg::bal_phase_t phase;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= bal_pkg::BAL_Q1;
        end else begin
            unique case (phase)
                bal_pkg::BAL_Q1: phase <= bal_pkg::BAL_Q2;
                bal_pkg::BAL_Q2: phase <= bal_pkg::BAL_Q3;
                bal_pkg::BAL_Q3: phase <= bal_pkg::BAL_Q4;
                bal_pkg::BAL_Q4: phase <= bal_pkg::BAL_Q1;
            endcase
        end
    end

    assign phase_o     = phase;
    assign cycle_end_o = (phase == bal_pkg::BAL_Q4);
endmodule

// [verif/bal_core_tb.sv]
// self-checking bench for the byte alu subset, driven over classic wishbone
// assumes bal_core with the register map of bal_defs.svh and a 100 MHz clock
`timescale 1ns/1ps
`include "bal_defs.svh"

module bal_core_tb;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        busy_o;
    int          fail_count = 0;
    int          cmp_count  = 0;

    always #5 clk_i = ~clk_i;

    bal_core dut (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .busy_o   (busy_o)
    );

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until the rising edge that samples ack; data taken there
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 50) chk("wb ack", 32'h0, 32'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb(1'b1, adr, dat, q);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] q);
        wb(1'b0, adr, 32'h0, q);
    endtask

    // loads operands, runs one command, then checks acc, file byte and flags
    task automatic do_op(input logic [1:0] op, input logic dst, input logic [6:0] fa,
                         input logic [7:0] lit, input logic [7:0] a, input logic [7:0] f,
                         input logic [2:0] st);
        logic [7:0]  res;
        logic [7:0]  ea;
        logic [7:0]  ef;
        logic [2:0]  es;
        logic [31:0] q;
        int          n;
        ea = a;
        ef = f;
        es = st;
        case (op)
            bal_pkg::BAL_SUB: begin
                res   = f - a;
                es[0] = (a <= f);
                es[1] = (a[3:0] <= f[3:0]);
            end
            bal_pkg::BAL_XORL: res = a ^ lit;
            bal_pkg::BAL_SWAP: res = {f[3:0], f[7:4]};
            default: res = a ^ f;
        endcase
        if (op != bal_pkg::BAL_SWAP) es[2] = (res == 8'h00);
        if (dst && op != bal_pkg::BAL_XORL) ef = res;
        else ea = res;
        wr(`BAL_OFF_FIDX, {25'h0, fa});
        wr(`BAL_OFF_FDATA, {24'h0, f});
        wr(`BAL_OFF_ACC, {24'h0, a});
        wr(`BAL_OFF_STATUS, {29'h0, st});
        wr(`BAL_OFF_CMD, {8'h00, lit, 1'b0, fa, 5'h00, dst, op});
        n = 1;
        @(negedge clk_i);
        while (busy_o !== 1'b0 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("busy span", 32'(n >= 5 && n <= 8), 32'h1);
        rd(`BAL_OFF_ACC, q);
        chk("acc", q, {24'h0, ea});
        rd(`BAL_OFF_FDATA, q);
        chk("file", q, {24'h0, ef});
        rd(`BAL_OFF_STATUS, q);
        chk("status", q, {29'h0, es});
    endtask

    task automatic t_reset;
        logic [31:0] q;
        rd(`BAL_OFF_ACC, q);
        chk("acc reset", q, 32'h0);
        rd(`BAL_OFF_STATUS, q);
        chk("status reset", q, 32'h0);
        rd(8'h40, q);
        chk("unmapped read", q, 32'h0);
        $display("reset test done");
    endtask

    // equal operands, borrow from both nibbles, top address, file destination
    task automatic t_sub;
        do_op(bal_pkg::BAL_SUB, 1'b0, 7'h00, 8'h00, 8'h10, 8'h10, 3'h0);
        do_op(bal_pkg::BAL_SUB, 1'b1, 7'h7F, 8'h00, 8'h11, 8'h10, 3'h7);
        do_op(bal_pkg::BAL_SUB, 1'b0, 7'h05, 8'h00, 8'h0F, 8'h10, 3'h0);
        do_op(bal_pkg::BAL_SUB, 1'b1, 7'h40, 8'h00, 8'h01, 8'hF0, 3'h4);
        $display("subtract test done");
    endtask

    task automatic t_xorl;
        do_op(bal_pkg::BAL_XORL, 1'b0, 7'h01, 8'h5A, 8'h5A, 8'h33, 3'h3);
        do_op(bal_pkg::BAL_XORL, 1'b1, 7'h02, 8'hFF, 8'h00, 8'h44, 3'h4);
        $display("literal xor test done");
    endtask

    task automatic t_swap;
        do_op(bal_pkg::BAL_SWAP, 1'b0, 7'h03, 8'h00, 8'h11, 8'hA5, 3'h7);
        do_op(bal_pkg::BAL_SWAP, 1'b1, 7'h7F, 8'h00, 8'h22, 8'h00, 3'h0);
        $display("swap test done");
    endtask

    task automatic t_xorf;
        do_op(bal_pkg::BAL_XORF, 1'b1, 7'h10, 8'h00, 8'h3C, 8'h3C, 3'h3);
        do_op(bal_pkg::BAL_XORF, 1'b0, 7'h7E, 8'h00, 8'h81, 8'h18, 3'h4);
        $display("register xor test done");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_sub;
        t_xorl;
        t_swap;
        t_xorf;
        end_of_test;
    end

    // tests need well under 2000 cycles; this leaves a wide margin
    initial begin
        #300000;
        fail_count++;
        end_of_test;
    end
endmodule
